// File: design/pair_buffer.sv
// two-entry buffer with valid and ready on both sides
// assumes source and sink on ref_clk; flush empties it in one edge
`timescale 1ns/1ns
module pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0]         mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wr_ptr;
    logic [$clog2(DEPTH)-1:0] rd_ptr;
    logic [$clog2(DEPTH):0]   count;
    logic                     push;
    logic                     pop;

    assign in_ready  = (count != DEPTH[$clog2(DEPTH):0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage only, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule : pair_buffer

// File: design/pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------
    // first stage is read by the second stage only
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta    <= '1;
            pin_out <= '1;
        end else begin
            meta    <= pin_in;
            pin_out <= meta;
        end
    end
endmodule : pin_sync

// File: design/uart_map_pkg.sv
// register map constants, field positions and carrier types of the uart register block
// assumes a synchronous 8-bit host bus on the same clock as the block
package uart_map_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_DATA   = 3'h0;
    localparam logic [2:0] ADDR_IEN    = 3'h1;
    localparam logic [2:0] ADDR_ISTAT  = 3'h2;
    localparam logic [2:0] ADDR_LINE   = 3'h3;
    localparam logic [2:0] ADDR_MODEM  = 3'h4;
    localparam logic [2:0] ADDR_LSTAT  = 3'h5;
    localparam logic [2:0] ADDR_MSTAT  = 3'h6;
    localparam logic [2:0] ADDR_SCR    = 3'h7;

    // ------------------------------------------------------------
    // key value and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_LOCK_KEY = 8'hbf;
    localparam int         LINE_DIV_BIT  = 7;
    localparam int         FIFO_EN_BIT   = 0;
    localparam int         RXF_RST_BIT   = 1;
    localparam int         TXF_RST_BIT   = 2;
    localparam int         LOOP_BIT      = 4;
    localparam logic [7:0] IEN_EXT_MASK  = 8'hf0;
    localparam logic [7:0] ISTAT_EXT_MASK = 8'h30;
    localparam logic [7:0] FIFO_EXT_MASK = 8'h38;
    localparam logic [7:0] MODEM_EXT_MASK = 8'he0;
    localparam logic [7:0] MODE_WR_MASK  = 8'hf0;
    localparam logic [7:0] EMS_WR_MASK   = 8'hcf;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [7:0] LINE_RST = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] ien;
        logic [7:0] fifo;
        logic [7:0] line;
        logic [7:0] modem;
        logic [7:0] mode;
        logic [7:0] ems;
    } ctrl_t;

    // modem inputs, active low at the pins
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } modem_pins_t;

endpackage : uart_map_pkg

// File: design/uart_regs.sv
// host register map of the uart: aliased addresses, gated extended bits
// assumes a synchronous host bus on ref_clk and an outside enhanced block
`timescale 1ns/1ns
module uart_regs
    import uart_map_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // host bus
    input  wire host_req_t   host_req,
    output logic      [7:0]  host_rdata,
    output logic             tx_space,
    // enhanced register block
    input  wire logic        enh_en,
    input  wire logic        feat_sel,
    // receiver side
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    output logic             rx_ready,
    // transmitter side
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    input  wire logic        tx_ready,
    // status from datapath and interrupt logic
    input  wire logic [7:0]  line_stat_in,
    input  wire logic [3:0]  int_source,
    input  wire logic        xoff_int,
    input  wire logic        rtscts_int,
    input  wire logic [7:0]  fifo_level,
    // modem pins
    input  wire modem_pins_t modem_n,
    output logic             dtr_n,
    output logic             rts_n,
    output logic             gen_out_one_n,
    output logic             int_out_en,
    // control towards the datapath
    output ctrl_t            ctrl,
    output logic             rx_fifo_reset,
    output logic             tx_fifo_reset
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ien;
    logic [7:0] fifo_ctl;
    logic [7:0] line;
    logic [7:0] modem;
    logic [7:0] mode;
    logic [7:0] ems;
    logic [7:0] scratch;
    logic [3:0] delta;
    logic [3:0] lvl_prev;
    logic [3:0] pin_lvl_n;
    logic [3:0] lvl;
    logic       rd_ok;
    logic       wr_ok;
    logic       rx_out_valid;
    logic [7:0] rx_out_byte;
    logic       rx_pop;
    logic       tx_push;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // access decode shared by read and write
    // ------------------------------------------------------------
    function automatic logic reach(input logic [2:0] a, input logic [7:0] lc,
                                   input logic en, input logic is_wr);
        logic unlocked;
        unlocked = (lc != LINE_LOCK_KEY);
        unique case (a)
            ADDR_DATA, ADDR_IEN: reach = !lc[LINE_DIV_BIT];
            ADDR_ISTAT: reach = en ? !lc[LINE_DIV_BIT] : unlocked;
            ADDR_LINE: reach = 1'b1;
            ADDR_MSTAT: reach = unlocked && (!is_wr || en);
            default: reach = unlocked;
        endcase
    endfunction : reach

    assign rd_ok   = host_req.rd && reach(host_req.addr, line, enh_en, 1'b0);
    assign wr_ok   = host_req.wr && reach(host_req.addr, line, enh_en, 1'b1);
    assign rx_pop  = rd_ok && (host_req.addr == ADDR_DATA);
    assign tx_push = wr_ok && (host_req.addr == ADDR_DATA);

    // ------------------------------------------------------------
    // data path buffers: a stalled transmitter fills the tx pair
    // ------------------------------------------------------------
    pair_buffer #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .flush     (rx_fifo_reset),
        .in_valid  (rx_valid),
        .in_data   (rx_byte),
        .in_ready  (rx_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_byte),
        .out_ready (rx_pop)
    );

    // a host write while tx_space is low is dropped; host polls tx_space
    pair_buffer #(.WIDTH(8), .DEPTH(2)) u_tx_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .flush     (tx_fifo_reset),
        .in_valid  (tx_push),
        .in_data   (host_req.wdata),
        .in_ready  (tx_space),
        .out_valid (tx_valid),
        .out_data  (tx_byte),
        .out_ready (tx_ready)
    );

    // ------------------------------------------------------------
    // modem inputs
    // ------------------------------------------------------------
    pin_sync #(.WIDTH(4)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin_in  (modem_n),
        .pin_out (pin_lvl_n)
    );

    // loopback feeds the inputs from modem control, pins are ignored
    assign lvl = modem[LOOP_BIT] ? {modem[3], modem[2], modem[0], modem[1]}
                                 : ~pin_lvl_n;

    // change flags: a change in the clearing read's cycle survives
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_prev <= 4'h0;
            delta    <= 4'h0;
        end else begin
            lvl_prev <= lvl;
            if (rd_ok && host_req.addr == ADDR_MSTAT) begin
                delta <= lvl ^ lvl_prev;
            end else begin
                delta <= delta | (lvl ^ lvl_prev);
            end
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ien      <= REG_RST;
            fifo_ctl <= REG_RST;
            line     <= LINE_RST;
            modem    <= REG_RST;
            mode     <= REG_RST;
            ems      <= REG_RST;
            scratch  <= REG_RST;
        end else if (wr_ok) begin
            unique case (host_req.addr)
                ADDR_IEN: ien <= host_req.wdata;
                ADDR_ISTAT: fifo_ctl <= host_req.wdata;
                ADDR_LINE: line <= host_req.wdata;
                ADDR_MODEM: modem <= host_req.wdata;
                ADDR_MSTAT: mode <= host_req.wdata & MODE_WR_MASK;
                ADDR_SCR: begin
                    if (feat_sel) ems <= host_req.wdata & EMS_WR_MASK;
                    else scratch <= host_req.wdata;
                end
                default: ;
            endcase
        end
    end

    // fifo resets are one-cycle pulses, and fifo_ctl also stores the written reset bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
        end else begin
            rx_fifo_reset <= wr_ok && host_req.addr == ADDR_ISTAT
                             && host_req.wdata[RXF_RST_BIT];
            tx_fifo_reset <= wr_ok && host_req.addr == ADDR_ISTAT
                             && host_req.wdata[TXF_RST_BIT];
        end
    end

    // ------------------------------------------------------------
    // effective controls, extended ien, fifo and modem bits gated by enhanced mode
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl.ien   <= enh_en ? ien : (ien & ~IEN_EXT_MASK);
            ctrl.fifo  <= enh_en ? fifo_ctl : (fifo_ctl & ~FIFO_EXT_MASK);
            ctrl.line  <= line;
            ctrl.modem <= enh_en ? modem : (modem & ~MODEM_EXT_MASK);
            ctrl.mode  <= mode;
            ctrl.ems   <= ems;
        end
    end

    // pins go inactive in loopback so the far end sees nothing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dtr_n         <= 1'b1;
            rts_n         <= 1'b1;
            gen_out_one_n <= 1'b1;
            int_out_en    <= 1'b0;
        end else begin
            dtr_n         <= !modem[0] || modem[LOOP_BIT];
            rts_n         <= !modem[1] || modem[LOOP_BIT];
            gen_out_one_n <= !modem[2] || modem[LOOP_BIT];
            int_out_en    <= modem[3] && !modem[LOOP_BIT];
        end
    end

    // ------------------------------------------------------------
    // read mux; unreached reads return zero
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (rd_ok) begin
            unique case (host_req.addr)
                ADDR_DATA: next_rdata = rx_out_byte;
                ADDR_IEN: next_rdata = enh_en ? ien : (ien & ~IEN_EXT_MASK);
                ADDR_ISTAT: begin
                    next_rdata = {{2{fifo_ctl[FIFO_EN_BIT]}}, rtscts_int,
                                  xoff_int, int_source};
                    if (!enh_en) next_rdata = next_rdata & ~ISTAT_EXT_MASK;
                end
                ADDR_LINE: next_rdata = line;
                ADDR_MODEM: next_rdata = enh_en ? modem : (modem & ~MODEM_EXT_MASK);
                ADDR_LSTAT: next_rdata = {line_stat_in[7:1], rx_out_valid};
                ADDR_MSTAT: next_rdata = {lvl, delta};
                default: next_rdata = feat_sel ? fifo_level : scratch;
            endcase
        end
    end

    // read data is held until the next read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= 8'h00;
        end else if (host_req.rd) begin
            host_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_rx_read_byte: assert property (
        rx_pop |=> host_rdata == $past(rx_out_byte))
        else $error("receive byte not returned at address 0");

    // a flush at the same edge empties the pair, so that case is left out
    chk_tx_write_out: assert property (
        tx_push && tx_space && !tx_valid && !tx_fifo_reset
        |=> tx_valid && tx_byte == $past(host_req.wdata))
        else $error("transmit byte not presented");

    chk_ien_locked: assert property (
        host_req.wr && host_req.addr == ADDR_IEN && line[LINE_DIV_BIT] |=> $stable(ien))
        else $error("interrupt enable written while divisor access on");

    chk_ien_ext_zero: assert property (
        rd_ok && host_req.addr == ADDR_IEN && !enh_en |=> host_rdata[7:4] == 4'h0)
        else $error("extended enable bits visible");

    chk_istat_fifo_bits: assert property (
        rd_ok && host_req.addr == ADDR_ISTAT
        |=> host_rdata[7:6] == {2{$past(fifo_ctl[FIFO_EN_BIT])}})
        else $error("fifo enabled bits wrong");

    chk_fifo_ctl_locked: assert property (
        host_req.wr && host_req.addr == ADDR_ISTAT && !enh_en && line == LINE_LOCK_KEY
        |=> $stable(fifo_ctl))
        else $error("fifo control written under lock key");

    chk_fifo_reset_pulse: assert property (
        rx_fifo_reset |=> !rx_out_valid && (!rx_fifo_reset || $past(wr_ok)))
        else $error("fifo reset held");

    chk_line_readback: assert property (
        wr_ok && host_req.addr == ADDR_LINE ##1 host_req.rd && !host_req.wr
        && host_req.addr == ADDR_LINE |=> host_rdata == $past(host_req.wdata, 2))
        else $error("line control readback wrong");

    chk_dtr_follows: assert property (
        !modem[LOOP_BIT] && $stable(modem) |=> dtr_n == !$past(modem[0]))
        else $error("dtr pin does not follow modem control");

    chk_modem_ext_gate: assert property (
        !enh_en && $stable(enh_en) |=> ctrl.modem[7:5] == 3'h0)
        else $error("extended modem bits active");

    chk_lstat_locked: assert property (
        host_req.rd && host_req.addr == ADDR_LSTAT && line == LINE_LOCK_KEY
        |=> host_rdata == 8'h00)
        else $error("line status read under lock key");

    chk_mode_low_zero: assert property (
        mode[3:0] == 4'h0)
        else $error("mode low nibble not zero");

    chk_level_read: assert property (
        rd_ok && host_req.addr == ADDR_SCR && feat_sel |=> host_rdata == $past(fifo_level))
        else $error("fifo level not returned");

    // every change seen by the compare stage must be kept in the flags
    chk_delta_set: assert property (
        lvl != lvl_prev
        |=> (delta & (lvl_prev ^ $past(lvl_prev))) == (lvl_prev ^ $past(lvl_prev)))
        else $error("modem change flag lost");

    chk_scratch_keep: assert property (
        host_req.wr && host_req.addr == ADDR_SCR && (line == LINE_LOCK_KEY || feat_sel)
        |=> $stable(scratch))
        else $error("scratch written while not selected");

    chk_ext_ctrl_gate: assert property (
        !enh_en |=> (ctrl.ien & IEN_EXT_MASK) == 8'h00 && (ctrl.fifo & FIFO_EXT_MASK) == 8'h00)
        else $error("extended control bits active");

    chk_loop_pins: assert property (
        modem[LOOP_BIT] |=> dtr_n && rts_n && gen_out_one_n && !int_out_en)
        else $error("modem pins active in loopback");

    cov_tx_full: cover property (!tx_space ##1 tx_ready);
    cov_delta_read: cover property (delta != 4'h0 ##1 rd_ok && host_req.addr == ADDR_MSTAT);
    cov_scratch_rt: cover property (wr_ok && host_req.addr == ADDR_SCR && !feat_sel);
endmodule : uart_regs

// File: dv/stream_far_end.sv
// far-end datapath model: receiver byte source and transmitter sink
// assumes the bench calls send just after a clock edge
`timescale 1ns/1ns
module stream_far_end (
    // clock
    input  wire logic       ref_clk,
    // receiver stream
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    input  wire logic       rx_ready,
    // transmitter stream
    input  wire logic       hold_tx,
    output logic            tx_ready
);
    logic ok;

    // sink takes every byte unless the bench stalls it
    assign tx_ready = !hold_tx;

    // source idles with nothing offered
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end

    // byte held until taken; ready is read after the edge so it holds at the next one
    task automatic send(input logic [7:0] b);
        rx_valid = 1'b1;
        rx_byte  = b;
        do begin
            ok = rx_ready;
            @(posedge ref_clk);
            #1;
        end while (!ok);
    endtask : send

    // release after the last byte; the data line is scrambled once released
    task automatic quit();
        rx_valid = 1'b0;
        rx_byte  = ~rx_byte;
    endtask : quit
endmodule : stream_far_end

// File: dv/uart_legacy_register_map_tb.sv
// bench for the uart register map: bus tasks, queued notes, monitor
// assumes stream_far_end stands on the receiver and transmitter streams
`timescale 1ns/1ns
module uart_legacy_register_map_tb;
    import uart_map_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    host_req_t   host_req = '0;
    modem_pins_t modem_n = '1;
    ctrl_t       ctrl;
    logic [7:0]  host_rdata, tx_byte, rx_byte, wd, fw, gate;
    logic [7:0]  mode_x = 8'h00, line_stat_in = 8'h00, fifo_level = 8'h00;
    logic [3:0]  int_source = 4'h0;
    logic        enh_en = 1'b0, feat_sel = 1'b0, xoff_int = 1'b0, rtscts_int = 1'b0;
    logic        hold_tx = 1'b0, rd_d = 1'b0;
    logic        tx_space, rx_valid, rx_ready, tx_valid, tx_ready;
    logic        dtr_n, rts_n, gen_out_one_n, int_out_en, rx_fifo_reset, tx_fifo_reset;
    logic [15:0] seed = 16'h867d;
    logic [7:0]  exp_q[$], tx_q[$];
    int          mismatches = 0, comparisons = 0, cycles = 0;

    uart_regs u_uart_regs (.ref_clk, .rst_n, .host_req, .host_rdata, .tx_space, .enh_en,
        .feat_sel, .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready,
        .line_stat_in, .int_source, .xoff_int, .rtscts_int, .fifo_level, .modem_n,
        .dtr_n, .rts_n, .gen_out_one_n, .int_out_en, .ctrl, .rx_fifo_reset, .tx_fifo_reset);
    stream_far_end u_stream_far_end (.ref_clk, .rx_valid, .rx_byte, .rx_ready, .hold_tx,
        .tx_ready);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    always #2 ref_clk = ~ref_clk;

    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // request held over exactly one edge; it stays on the bus until the next task call replaces it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #1;
    endtask : rd

    task automatic idle(input int n);
        host_req = '0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // read data lands one edge after the read; pops are seen at their edge
    always @(posedge ref_clk) begin
        if (rd_d) check(host_rdata, exp_q.pop_front());
        if (tx_valid === 1'b1 && tx_ready) check(tx_byte, tx_q.pop_front());
        rd_d <= host_req.rd & rst_n;
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rd(ADDR_LINE, LINE_RST);
        rd(ADDR_MODEM, REG_RST);
        check({4'h0, dtr_n, rts_n, gen_out_one_n, int_out_en}, 8'h0e);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            enh_en = i[0];
            gate = {8{i[0]}};
            wd = rnd();
            wr(ADDR_LINE, {1'b0, wd[6:0]});
            rd(ADDR_LINE, {1'b0, wd[6:0]});
            check(ctrl.line, {1'b0, wd[6:0]});
            wr(ADDR_SCR, wd);
            rd(ADDR_SCR, wd);
            wr(ADDR_IEN, wd);
            rd(ADDR_IEN, wd & (gate | ~IEN_EXT_MASK));
            check(ctrl.ien, wd & (gate | ~IEN_EXT_MASK));
            wr(ADDR_MODEM, wd & 8'hef);
            rd(ADDR_MODEM, wd & 8'hef & (gate | ~MODEM_EXT_MASK));
            check(ctrl.modem, wd & 8'hef & (gate | ~MODEM_EXT_MASK));
            check({4'h0, dtr_n, rts_n, gen_out_one_n, int_out_en},
                  {4'h0, ~wd[0], ~wd[1], ~wd[2], wd[3]});
            fw = wd;
            wr(ADDR_ISTAT, fw);
            {rtscts_int, xoff_int, int_source} = wd[5:0];
            rd(ADDR_ISTAT, {fw[0], fw[0], wd[5:4] & gate[1:0], wd[3:0]});
            check(ctrl.fifo, fw & (gate | ~FIFO_EXT_MASK));
            line_stat_in = wd;
            rd(ADDR_LSTAT, {wd[7:1], 1'b0});
            wr(ADDR_MSTAT, ~wd);
            if (enh_en) mode_x = ~wd & MODE_WR_MASK;
            fifo_level = ~wd;
            feat_sel = 1'b1;
            rd(ADDR_SCR, ~wd);
            wr(ADDR_SCR, wd ^ 8'h3c);
            feat_sel = 1'b0;
            rd(ADDR_SCR, wd);
            check(ctrl.mode, mode_x);
            check(ctrl.ems, (wd ^ 8'h3c) & EMS_WR_MASK);
        end
        $display("register loop done");
        wr(ADDR_LINE, LINE_LOCK_KEY);
        for (int a = 0; a < 8; a++) if (a != 3) rd(a[2:0], 8'h00);
        // refused writes under the lock key and under divisor access
        enh_en = 1'b0;
        wr(ADDR_ISTAT, ~fw);
        rd(ADDR_ISTAT, 8'h00);
        wr(ADDR_LINE, 8'h80);
        wr(ADDR_IEN, 8'hff);
        rd(ADDR_IEN, 8'h00);
        rd(ADDR_ISTAT, {fw[0], fw[0], 2'b00, int_source});
        wr(ADDR_LINE, 8'h00);
        rd(ADDR_IEN, wd & ~IEN_EXT_MASK);
        modem_n.cts_n = 1'b0;
        idle(6);
        rd(ADDR_MSTAT, 8'h11);
        rd(ADDR_MSTAT, 8'h10);
        // loopback: cts from rts, dsr from dtr, ri from op1, cd from op2
        wr(ADDR_MODEM, 8'h1b);
        idle(2);
        check({4'h0, dtr_n, rts_n, gen_out_one_n, int_out_en}, 8'h0e);
        rd(ADDR_MSTAT, 8'hba);
        rd(ADDR_MSTAT, 8'hb0);
        wr(ADDR_MODEM, 8'h00);
        $display("lock and modem status done");
        hold_tx = 1'b1;
        wd = rnd();
        tx_q.push_back(wd);
        tx_q.push_back(~wd);
        wr(ADDR_DATA, wd);
        wr(ADDR_DATA, ~wd);
        idle(1);
        check({7'h00, tx_space}, 8'h00);
        wr(ADDR_DATA, 8'h5a);
        hold_tx = 1'b0;
        fork
            begin
                for (int k = 0; k < 3; k++) u_stream_far_end.send(wd + k[7:0]);
                u_stream_far_end.quit();
            end
        join_none
        idle(4);
        check({7'h00, rx_ready}, 8'h00);
        rd(ADDR_LSTAT, {line_stat_in[7:1], 1'b1});
        rd(ADDR_DATA, wd);
        rd(ADDR_DATA, wd + 8'h01);
        idle(3);
        rd(ADDR_DATA, wd + 8'h02);
        rd(ADDR_LSTAT, {line_stat_in[7:1], 1'b0});
        idle(3);
        $display("data path done");
        print_verdict();
    end
endmodule : uart_legacy_register_map_tb
